//--- tbu_pkg.sv
// constants, types and register map of the six-channel timer unit
package tbu_pkg;

  localparam int unsigned TBU_NUM_CH          = 6;
  localparam int unsigned TBU_CNT_W           = 16;
  localparam int unsigned TBU_ADDR_W          = 8;
  localparam int unsigned TBU_DATA_W          = 32;

  localparam logic [7:0]  TBU_CNT_OFF         = 8'h00;
  localparam logic [7:0]  TBU_MODE_OFF        = 8'h04;
  localparam logic [7:0]  TBU_CH_STRIDE       = 8'h10;
  localparam logic [7:0]  TBU_RUN_FIRST_ADDR  = 8'h60;
  localparam logic [7:0]  TBU_RUN_SECOND_ADDR = 8'h64;

  localparam int unsigned TBU_RUN_LSB         = 5;
  localparam int unsigned TBU_RUN_PER_REG     = 3;

  localparam logic [7:0]  TBU_MODE_RST        = 8'h00;
  localparam logic [15:0] TBU_CNT_RST         = 16'h0000;
  localparam logic [2:0]  TBU_RUN_RST         = 3'h0;

  localparam int unsigned TBU_DIV_MID         = 8;
  localparam int unsigned TBU_DIV_SLOW        = 32;

  typedef enum logic [1:0] {
    TBU_TIMER,
    TBU_EVENT,
    TBU_MEASURE,
    TBU_RSVD
  } tbu_mode_e;

  typedef enum logic [1:0] {
    TBU_IDLE,
    TBU_ARMED,
    TBU_COUNTING
  } tbu_phase_e;

  // layout of channel_mode_register, msb first
  typedef struct packed {
    logic [1:0] src_sel;
    logic       ovf_bit;
    logic       chain_sel;
    logic [1:0] edge_sel;
    tbu_mode_e  mode;
  } tbu_mode_s;

  typedef struct packed {
    logic [TBU_ADDR_W-1:0] addr;
    logic [TBU_DATA_W-1:0] wdata;
    logic                  wr;
    logic                  rd;
  } tbu_bus_req_s;

endpackage : tbu_pkg

//--- tbu_prescaler.sv
// free-running divider making the prescaled count ticks
`timescale 1ns/1ps
module tbu_prescaler #(
  parameter int unsigned DIV_MID  = tbu_pkg::TBU_DIV_MID,
  parameter int unsigned DIV_SLOW = tbu_pkg::TBU_DIV_SLOW
) (
  input  wire logic core_clk,
  input  wire logic reset,
  output logic      tick_mid,
  output logic      tick_slow
);
  import tbu_pkg::*;

  localparam int unsigned SW = $clog2(DIV_SLOW);
  localparam int unsigned MW = $clog2(DIV_MID);

  logic [SW-1:0] div_reg;

  always_ff @(posedge core_clk) begin
    if (reset) begin
      div_reg <= '0;
    end else begin
      div_reg <= div_reg + 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      tick_mid  <= 1'b0;
      tick_slow <= 1'b0;
    end else begin
      tick_mid  <= (div_reg[MW-1:0] == '1);
      tick_slow <= (div_reg == '1);
    end
  end

endmodule : tbu_prescaler

//--- tbu_edge_sync.sv
// two-stage synchroniser with edge detection on a registered copy
`timescale 1ns/1ps
module tbu_edge_sync #(
  parameter int unsigned W = 7
) (
  input  wire logic         core_clk,
  input  wire logic         reset,
  input  wire logic [W-1:0] pin_in,
  output logic      [W-1:0] rise,
  output logic      [W-1:0] fall
);
  import tbu_pkg::*;

  logic [W-1:0] meta_reg;
  logic [W-1:0] sync_reg;
  logic [W-1:0] prev_reg;

  always_ff @(posedge core_clk) begin
    if (reset) begin
      meta_reg <= '0;
      sync_reg <= '0;
      prev_reg <= '0;
    end else begin
      meta_reg <= pin_in;
      sync_reg <= meta_reg;
      prev_reg <= sync_reg;
    end
  end

  assign rise = sync_reg & ~prev_reg;
  assign fall = ~sync_reg & prev_reg;

endmodule : tbu_edge_sync

//--- tbu_timer_b.sv
// six-channel 16-bit timer unit: timer, event counter and pulse measurement
//
// What this block does
// - six channels, two-bit mode field each
// - timer mode decrements on prescaled ticks
// - underflow reloads, continues, requests interrupt
// - setting n gives underflow every n+1
// - run bit starts and stops counting
// - run bits at bits 5-7, two registers
// - count read returns counter in counting modes
// - write before first tick loads both
// - later writes update reload only
// - event mode counts pin edges or chain
// - chain source previous, wrapping per group
// - measurement up-counts prescaled ticks
// - edge copies count, restarts from zero
// - edges request interrupt, except first one
// - overflow requests interrupt, sets flag
// - flag clears on mode write after a further prescaled tick
// - measurement read returns captured result
// - measurement ignores count register writes
`timescale 1ns/1ps
module tbu_timer_b #(
  parameter int unsigned CNT_W    = tbu_pkg::TBU_CNT_W,
  parameter int unsigned DIV_MID  = tbu_pkg::TBU_DIV_MID,
  parameter int unsigned DIV_SLOW = tbu_pkg::TBU_DIV_SLOW
) (
  input  wire logic                                  core_clk,
  input  wire logic                                  reset,
  input  tbu_pkg::tbu_bus_req_s                      bus_req,
  output logic        [tbu_pkg::TBU_DATA_W-1:0]      bus_rdata,
  input  wire logic   [tbu_pkg::TBU_NUM_CH-1:0]      channel_input_pin,
  input  wire logic                                  subclock_div32_tick,
  output logic        [tbu_pkg::TBU_NUM_CH-1:0]      irq_pulse,
  output logic        [tbu_pkg::TBU_NUM_CH-1:0]      chain_out
);
  import tbu_pkg::*;

  localparam int unsigned NCH = TBU_NUM_CH;

  // address of a channel register
  function automatic logic [7:0] ch_addr(input int unsigned ch, input logic [7:0] off);
    return 8'(ch) * TBU_CH_STRIDE + off;
  endfunction : ch_addr

  // chained source channel
  function automatic int unsigned prev_ch(input int unsigned ch);
    if (ch == 0) begin
      return 2;
    end else if (ch == 3) begin
      return 5;
    end else begin
      return ch - 1;
    end
  endfunction : prev_ch

  // effective edge selection
  function automatic logic eff_edge(input logic [1:0] sel, input logic r, input logic f);
    case (sel)
      2'h0:    return f;
      2'h1:    return r;
      default: return r | f;
    endcase
  endfunction : eff_edge

  logic [CNT_W-1:0]   cnt_reg    [NCH];
  logic [CNT_W-1:0]   reload_reg [NCH];
  tbu_mode_s          cfg_reg    [NCH];
  tbu_phase_e         phase_reg  [NCH];
  logic [NCH-1:0]     ovf_flag_reg;
  logic [NCH-1:0]     ovf_armed_reg;
  logic [2:0]         run_first_reg;
  logic [2:0]         run_second_reg;

  logic [NCH-1:0]     run;
  logic [NCH:0]       pin_rise;
  logic [NCH:0]       pin_fall;
  logic               tick_mid;
  logic               tick_slow;
  logic [NCH-1:0]     src_tick;
  logic [NCH-1:0]     pin_edge;
  logic [NCH-1:0]     count_tick;
  logic [NCH-1:0]     is_down;
  logic [NCH-1:0]     is_meas;
  logic [NCH-1:0]     active;
  logic [NCH-1:0]     wr_cnt;
  logic [NCH-1:0]     wr_mode;
  logic [NCH-1:0]     uf_evt;
  logic [NCH-1:0]     ovf_evt;
  logic [NCH-1:0]     meas_evt;
  logic [TBU_DATA_W-1:0] rd_value;

  tbu_prescaler #(
    .DIV_MID  (DIV_MID),
    .DIV_SLOW (DIV_SLOW)
  ) u_presc (
    .core_clk  (core_clk),
    .reset     (reset),
    .tick_mid  (tick_mid),
    .tick_slow (tick_slow)
  );

  // pins and subclock synchronised together
  tbu_edge_sync #(
    .W (NCH + 1)
  ) u_sync (
    .core_clk (core_clk),
    .reset    (reset),
    .pin_in   ({subclock_div32_tick, channel_input_pin}),
    .rise     (pin_rise),
    .fall     (pin_fall)
  );

  assign run = {run_second_reg, run_first_reg};

  // per-channel tick and event decode
  always_comb begin
    for (int i = 0; i < NCH; i++) begin
      is_down[i]  = (cfg_reg[i].mode == TBU_TIMER) || (cfg_reg[i].mode == TBU_EVENT);
      is_meas[i]  = (cfg_reg[i].mode == TBU_MEASURE);
      active[i]   = run[i] && (phase_reg[i] != TBU_IDLE);
      case (cfg_reg[i].src_sel)
        2'h0:    src_tick[i] = 1'b1;
        2'h1:    src_tick[i] = tick_mid;
        2'h2:    src_tick[i] = tick_slow;
        default: src_tick[i] = pin_rise[NCH];
      endcase
      pin_edge[i] = eff_edge(cfg_reg[i].edge_sel, pin_rise[i], pin_fall[i]);
      if (cfg_reg[i].mode == TBU_EVENT) begin
        if (cfg_reg[i].chain_sel) begin
          count_tick[i] = chain_out[prev_ch(i)];
        end else begin
          count_tick[i] = pin_edge[i];
        end
      end else begin
        count_tick[i] = src_tick[i];
      end
      wr_cnt[i]   = bus_req.wr && (bus_req.addr == ch_addr(i, TBU_CNT_OFF));
      wr_mode[i]  = bus_req.wr && (bus_req.addr == ch_addr(i, TBU_MODE_OFF));
      uf_evt[i]   = is_down[i] && active[i] && count_tick[i] && (cnt_reg[i] == '0);
      meas_evt[i] = is_meas[i] && active[i] && pin_edge[i];
      ovf_evt[i]  = is_meas[i] && active[i] && !pin_edge[i] && src_tick[i]
                    && (cnt_reg[i] == '1);
    end
  end

  // counter and reload registers
  always_ff @(posedge core_clk) begin
    if (reset) begin
      for (int i = 0; i < NCH; i++) begin
        cnt_reg[i]    <= CNT_W'(TBU_CNT_RST);
        reload_reg[i] <= CNT_W'(TBU_CNT_RST);
      end
    end else begin
      for (int i = 0; i < NCH; i++) begin
        if (is_down[i]) begin
          if (active[i] && count_tick[i]) begin
            if (cnt_reg[i] == '0) begin
              cnt_reg[i] <= reload_reg[i];
            end else begin
              cnt_reg[i] <= cnt_reg[i] - 1'b1;
            end
          end
          if (wr_cnt[i]) begin
            reload_reg[i] <= bus_req.wdata[CNT_W-1:0];
            if ((phase_reg[i] != TBU_COUNTING) || !run[i]) begin
              cnt_reg[i] <= bus_req.wdata[CNT_W-1:0];
            end
          end
        end else if (is_meas[i] && active[i]) begin
          if (pin_edge[i]) begin
            reload_reg[i] <= cnt_reg[i];
            cnt_reg[i]    <= '0;
          end else if (src_tick[i]) begin
            cnt_reg[i] <= cnt_reg[i] + 1'b1;
          end
        end
        // count writes dropped in measurement mode
      end
    end
  end

  // channel phase: stopped, started, counting
  always_ff @(posedge core_clk) begin
    if (reset) begin
      for (int i = 0; i < NCH; i++) begin
        phase_reg[i] <= TBU_IDLE;
      end
    end else begin
      for (int i = 0; i < NCH; i++) begin
        case (phase_reg[i])
          TBU_IDLE: begin
            if (run[i]) begin
              phase_reg[i] <= TBU_ARMED;
            end
          end
          TBU_ARMED: begin
            if (!run[i]) begin
              phase_reg[i] <= TBU_IDLE;
            end else if ((is_down[i] && count_tick[i]) || meas_evt[i]) begin
              phase_reg[i] <= TBU_COUNTING;
            end
          end
          TBU_COUNTING: begin
            if (!run[i]) begin
              phase_reg[i] <= TBU_IDLE;
            end
          end
          default: begin
            phase_reg[i] <= TBU_IDLE;
          end
        endcase
      end
    end
  end

  // interrupt request and chain pulses
  always_ff @(posedge core_clk) begin
    if (reset) begin
      irq_pulse <= '0;
      chain_out <= '0;
    end else begin
      for (int i = 0; i < NCH; i++) begin
        irq_pulse[i] <= uf_evt[i]
                        || (meas_evt[i] && (phase_reg[i] == TBU_COUNTING))
                        || ovf_evt[i];
        chain_out[i] <= uf_evt[i] || ovf_evt[i];
      end
    end
  end

  // measurement overflow flag; a set beats a clear
  always_ff @(posedge core_clk) begin
    if (reset) begin
      ovf_flag_reg  <= '0;
      ovf_armed_reg <= '0;
    end else begin
      for (int i = 0; i < NCH; i++) begin
        if (ovf_evt[i]) begin
          ovf_flag_reg[i]  <= 1'b1;
          ovf_armed_reg[i] <= 1'b0;
        end else if (wr_mode[i] && ovf_armed_reg[i]) begin
          ovf_flag_reg[i]  <= 1'b0;
          ovf_armed_reg[i] <= 1'b0;
        end else if (ovf_flag_reg[i] && active[i] && src_tick[i]) begin
          ovf_armed_reg[i] <= 1'b1;
        end
      end
    end
  end

  // mode configuration
  always_ff @(posedge core_clk) begin
    if (reset) begin
      for (int i = 0; i < NCH; i++) begin
        cfg_reg[i] <= tbu_mode_s'(TBU_MODE_RST);
      end
    end else begin
      for (int i = 0; i < NCH; i++) begin
        if (wr_mode[i]) begin
          cfg_reg[i] <= tbu_mode_s'(bus_req.wdata[7:0]);
        end
      end
    end
  end

  // run-control registers
  always_ff @(posedge core_clk) begin
    if (reset) begin
      run_first_reg  <= TBU_RUN_RST;
      run_second_reg <= TBU_RUN_RST;
    end else begin
      if (bus_req.wr && (bus_req.addr == TBU_RUN_FIRST_ADDR)) begin
        run_first_reg <= bus_req.wdata[TBU_RUN_LSB +: TBU_RUN_PER_REG];
      end
      if (bus_req.wr && (bus_req.addr == TBU_RUN_SECOND_ADDR)) begin
        run_second_reg <= bus_req.wdata[TBU_RUN_LSB +: TBU_RUN_PER_REG];
      end
    end
  end

  // read mux
  always_comb begin
    rd_value = '0;
    if (bus_req.addr == TBU_RUN_FIRST_ADDR) begin
      rd_value[TBU_RUN_LSB +: TBU_RUN_PER_REG] = run_first_reg;
    end
    if (bus_req.addr == TBU_RUN_SECOND_ADDR) begin
      rd_value[TBU_RUN_LSB +: TBU_RUN_PER_REG] = run_second_reg;
    end
    for (int i = 0; i < NCH; i++) begin
      if (bus_req.addr == ch_addr(i, TBU_CNT_OFF)) begin
        if (is_meas[i]) begin
          rd_value[CNT_W-1:0] = reload_reg[i];
        end else begin
          rd_value[CNT_W-1:0] = cnt_reg[i];
        end
      end
      if (bus_req.addr == ch_addr(i, TBU_MODE_OFF)) begin
        rd_value[7:0] = {cfg_reg[i].src_sel, ovf_flag_reg[i], cfg_reg[i].chain_sel,
                         cfg_reg[i].edge_sel, cfg_reg[i].mode};
      end
    end
  end

  // read data in the cycle after the strobe
  always_ff @(posedge core_clk) begin
    if (reset) begin
      bus_rdata <= '0;
    end else if (bus_req.rd) begin
      bus_rdata <= rd_value;
    end else begin
      bus_rdata <= '0;
    end
  end

endmodule : tbu_timer_b

//--- tbu_timer_b_monitor.sv
// port checker for the six-channel timer unit
`timescale 1ns/1ps
module tbu_timer_b_monitor
  import tbu_pkg::*;
#(
  parameter int unsigned CNT_W    = TBU_CNT_W,
  parameter int unsigned DIV_MID  = TBU_DIV_MID,
  parameter int unsigned DIV_SLOW = TBU_DIV_SLOW
) (
  input wire logic                  core_clk,
  input wire logic                  reset,
  input tbu_pkg::tbu_bus_req_s      bus_req,
  input wire logic [TBU_DATA_W-1:0] bus_rdata,
  input wire logic [TBU_NUM_CH-1:0] channel_input_pin,
  input wire logic                  subclock_div32_tick,
  input wire logic [TBU_NUM_CH-1:0] irq_pulse,
  input wire logic [TBU_NUM_CH-1:0] chain_out
);
  logic [5:0] run_m;

  // mirror of the run bits seen on the bus
  always_ff @(posedge core_clk) begin
    if (reset) begin
      run_m <= '0;
    end else if (bus_req.wr && bus_req.addr == TBU_RUN_FIRST_ADDR) begin
      run_m[2:0] <= bus_req.wdata[7:5];
    end else if (bus_req.wr && bus_req.addr == TBU_RUN_SECOND_ADDR) begin
      run_m[5:3] <= bus_req.wdata[7:5];
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);

  chk_rdata_idle: assert property (!$past(bus_req.rd) |-> bus_rdata == '0)
    else $error("read data not zero outside read cycle");
  chk_reset_quiet: assert property (disable iff (1'b0)
    reset |=> (irq_pulse == '0 && chain_out == '0 && bus_rdata == '0))
    else $error("outputs active after reset");
  chk_unmapped_rd: assert property (bus_req.rd && bus_req.addr == 8'hF0 |=> bus_rdata == '0)
    else $error("unmapped read not zero");
  chk_cnt_width: assert property (bus_req.rd && bus_req.addr < 8'h60
    && bus_req.addr[3:0] == 4'h0 |=> bus_rdata[31:16] == 16'h0000)
    else $error("count read wider than 16 bits");
  chk_mode_width: assert property (bus_req.rd && bus_req.addr < 8'h60
    && bus_req.addr[3:0] == 4'h4 |=> bus_rdata[31:8] == 24'h000000)
    else $error("mode read wider than 8 bits");
  chk_run_first: assert property (bus_req.rd && bus_req.addr == TBU_RUN_FIRST_ADDR
    |=> bus_rdata[7:5] == $past(run_m[2:0]))
    else $error("first run register mismatch");
  chk_run_second: assert property (bus_req.rd && bus_req.addr == TBU_RUN_SECOND_ADDR
    |=> bus_rdata[7:5] == $past(run_m[5:3]))
    else $error("second run register mismatch");
  chk_irq_run: assert property ((irq_pulse & ~($past(run_m) | $past(run_m, 2))) == '0)
    else $error("interrupt from stopped channel");
  chk_chain_irq: assert property ((chain_out & ~irq_pulse) == '0)
    else $error("chain pulse without interrupt");

  cover property (irq_pulse[0]);
  cover property (chain_out[2]);
  cover property ($rose(irq_pulse[3]));
endmodule : tbu_timer_b_monitor

bind tbu_timer_b tbu_timer_b_monitor #(
  .CNT_W(CNT_W),
  .DIV_MID(DIV_MID),
  .DIV_SLOW(DIV_SLOW)
) i_tbu_timer_b_monitor (
  .core_clk(core_clk),
  .reset(reset),
  .bus_req(bus_req),
  .bus_rdata(bus_rdata),
  .channel_input_pin(channel_input_pin),
  .subclock_div32_tick(subclock_div32_tick),
  .irq_pulse(irq_pulse),
  .chain_out(chain_out)
);

//--- tbu_pulse_src.sv
// external pulse source on the channel input pins
`timescale 1ns/1ps
module tbu_pulse_src (
  input  wire logic       core_clk,
  input  wire logic       reset,
  input  wire logic [7:0] half,
  input  wire logic [5:0] en,
  output logic      [5:0] channel_input_pin
);
  logic [7:0] cnt;

  // square wave on enabled pins, low otherwise
  always_ff @(posedge core_clk) begin
    if (reset || en == '0) begin
      cnt <= 8'h00;
      channel_input_pin <= '0;
    end else if (cnt == half - 8'h01) begin
      cnt <= 8'h00;
      channel_input_pin <= ~channel_input_pin & en;
    end else begin
      cnt <= cnt + 8'h01;
    end
  end
endmodule : tbu_pulse_src

//--- test_tbu_timer_b.sv
// self-checking bench for the six-channel timer unit
`timescale 1ns/1ps
module test_tbu_timer_b;
  import tbu_pkg::*;
  logic                  core_clk = 1'b0;
  logic                  reset;
  tbu_bus_req_s          bus_req;
  logic [TBU_DATA_W-1:0] bus_rdata;
  logic [5:0]            pin;
  logic [5:0]            en;
  logic [4:0]            sub_cnt = 5'h00;
  logic [5:0]            irq_pulse;
  logic [5:0]            chain_out;
  int                    err_total = 0;
  int                    checks = 0;
  int                    cyc = 0;
  int                    icnt3 = 0;
  int                    ccnt2 = 0;
  int                    exp_src [4] = '{2, 16, 64, 64};

  always #5 core_clk = ~core_clk;
  always @(posedge core_clk) sub_cnt <= sub_cnt + 5'h01;
  always @(posedge core_clk) if (irq_pulse[3] === 1'b1) icnt3++;
  always @(posedge core_clk) if (chain_out[2] === 1'b1) ccnt2++;
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 10000) begin
      err_total++;
      end_of_test();
    end
  end

  tbu_timer_b #(.CNT_W(10)) i_tbu_timer_b (
    .core_clk(core_clk),
    .reset(reset),
    .bus_req(bus_req),
    .bus_rdata(bus_rdata),
    .channel_input_pin(pin),
    .subclock_div32_tick(sub_cnt[4]),
    .irq_pulse(irq_pulse),
    .chain_out(chain_out)
  );

  tbu_pulse_src i_tbu_pulse_src (
    .core_clk(core_clk),
    .reset(reset),
    .half(8'h05),
    .en(en),
    .channel_input_pin(pin)
  );

  task automatic end_of_test;
    $display("checks=%0d err_total=%0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : end_of_test

  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_val

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    bus_req.addr  <= a;
    bus_req.wdata <= d;
    bus_req.wr    <= 1'b1;
    @(posedge core_clk);
    bus_req.wr    <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge core_clk);
    bus_req.addr <= a;
    bus_req.rd   <= 1'b1;
    @(posedge core_clk);
    bus_req.rd   <= 1'b0;
    #1;
    d = bus_rdata;
  endtask : rd

  task automatic rc(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    rd(a, d);
    chk_val(d, exp);
  endtask : rc

  task automatic wait_irq(input int ch, output int n);
    n = 0;
    do begin
      @(posedge core_clk);
      #1;
      n++;
    end while (irq_pulse[ch] !== 1'b1 && n < 2000);
    if (n >= 2000) err_total++;
  endtask : wait_irq

  task automatic per(input int ch, input int exp);
    int n;
    wait_irq(ch, n);
    wait_irq(ch, n);
    chk_val(32'(n), 32'(exp));
  endtask : per

  initial begin
    logic [31:0] d1;
    logic [31:0] d2;
    int          n;
    bus_req = '0;
    en = '0;
    reset = 1'b1;
    repeat (6) @(posedge core_clk);
    reset <= 1'b0;
    for (int i = 0; i < 6; i++) begin
      rc(8'(16 * i), 32'h0);
      rc(8'(16 * i + 4), 32'h0);
    end
    rc(TBU_RUN_SECOND_ADDR, 32'h0);
    rc(8'hF0, 32'h0);
    // timer reload, period and write-while-running
    wr(8'h04, 32'h00);
    wr(8'h00, 32'h3);
    rc(8'h00, 32'h3);
    wr(TBU_RUN_FIRST_ADDR, 32'h20);
    per(0, 4);
    wr(8'h00, 32'h7);
    per(0, 8);
    wr(TBU_RUN_FIRST_ADDR, 32'h00);
    rd(8'h00, d1);
    repeat (10) @(posedge core_clk);
    rd(8'h00, d2);
    chk_val(d2, d1);
    // channel 0 counts underflows of channel 2
    wr(8'h04, 32'h11);
    wr(8'h00, 32'h1);
    wr(8'h24, 32'h00);
    wr(8'h20, 32'h3);
    wr(TBU_RUN_FIRST_ADDR, 32'hA0);
    rc(TBU_RUN_FIRST_ADDR, 32'hA0);
    per(0, 8);
    ccnt2 = 0;
    repeat (16) @(posedge core_clk);
    #1;
    chk_val(32'(ccnt2), 32'h4);
    wr(TBU_RUN_FIRST_ADDR, 32'h00);
    for (int s = 0; s < 4; s++) begin
      wr(8'h44, 32'(s << 6));
      wr(8'h40, 32'h1);
      wr(TBU_RUN_SECOND_ADDR, 32'h40);
      per(4, exp_src[s]);
      wr(TBU_RUN_SECOND_ADDR, 32'h00);
    end
    // channel 5 counts rising pin edges
    wr(8'h54, 32'h05);
    wr(8'h50, 32'h1);
    wr(8'h34, 32'h11);
    wr(8'h30, 32'h1);
    wr(TBU_RUN_SECOND_ADDR, 32'hA0);
    rc(TBU_RUN_SECOND_ADDR, 32'hA0);
    @(posedge core_clk) en <= 6'h20;
    per(5, 20);
    per(3, 40);
    wr(TBU_RUN_SECOND_ADDR, 32'h00);
    @(posedge core_clk) en <= 6'h00;
    // channel 1 counts falling pin edges
    wr(8'h14, 32'h01);
    wr(8'h10, 32'h1);
    wr(TBU_RUN_FIRST_ADDR, 32'h40);
    @(posedge core_clk) en <= 6'h02;
    per(1, 20);
    wr(TBU_RUN_FIRST_ADDR, 32'h00);
    @(posedge core_clk) en <= 6'h00;
    // channel 3 measures a ten-cycle period
    wr(8'h34, 32'h06);
    wr(TBU_RUN_SECOND_ADDR, 32'h20);
    @(posedge core_clk) en <= 6'h08;
    icnt3 = 0;
    repeat (32) @(posedge core_clk);
    en <= 6'h00;
    chk_val(32'(icnt3), 32'h2);
    rc(8'h30, 32'h9);
    wr(8'h30, 32'h1234);
    rc(8'h30, 32'h9);
    wait_irq(3, n);
    rc(8'h34, 32'h26);
    wr(8'h34, 32'h06);
    rc(8'h34, 32'h06);
    // width of a five-cycle high phase
    wr(8'h34, 32'h0A);
    @(posedge core_clk) en <= 6'h08;
    repeat (32) @(posedge core_clk);
    en <= 6'h00;
    rc(8'h30, 32'h4);
    end_of_test();
  end
endmodule : test_tbu_timer_b
